/* File: hdl/flash_bus_cycle.sv */
// one asynchronous read or write cycle on the flash pins
`timescale 1ns/1ps
`default_nettype none
module flash_bus_cycle (
    input wire logic core_clk_i,
    input wire logic rst_i,
    input wire logic start_i,
    input wire logic write_i,
    input wire logic ce_ctrl_i,
    input wire logic [flash_host_pkg::ADDR_W-1:0] addr_i,
    input wire logic [flash_host_pkg::DATA_W-1:0] data_i,
    input wire logic [flash_host_pkg::DATA_W-1:0] dq_i,
    output flash_host_pkg::pins_t pins_o,
    output logic [flash_host_pkg::DATA_W-1:0] rdata_o,
    output logic done_o
);
    import flash_host_pkg::*;

    typedef enum logic [2:0] {CY_IDLE, CY_READ, CY_STROBE, CY_HOLD, CY_RECOVER} cy_st_t;

    typedef struct packed {
        cy_st_t st;
        logic [CNT_W-1:0] cnt;
        pins_t pins;
        logic [DATA_W-1:0] rdata;
        logic done;
        logic [DATA_W-1:0] s1;
        logic [DATA_W-1:0] s2;
        logic [DATA_W-1:0] s3;
    } cy_state_t;

    localparam cy_state_t CY_RESET = '{st: CY_IDLE, cnt: '0, pins: PINS_IDLE, rdata: '0,
                                     done: 1'b0, s1: '0, s2: '0, s3: '0};

    cy_state_t state_q;
    cy_state_t state_d;

    // ------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------
    always_comb begin
        state_d = state_q;
        state_d.done = 1'b0;
        state_d.s1 = dq_i;
        state_d.s2 = state_q.s1;
        state_d.s3 = state_q.s2;
        state_d.cnt = state_q.cnt + 1'b1;
        case (state_q.st)
            CY_IDLE: begin
                state_d.cnt = '0;
                if (start_i) begin
                    state_d.pins.addr = addr_i;
                    if (write_i) begin
                        // strobe pin pulses, the other is held low
                        state_d.st = CY_STROBE;
                        state_d.pins.dq = data_i;
                        state_d.pins.dq_oe = 1'b1;
                        state_d.pins.ce_n = 1'b0;
                        state_d.pins.we_n = 1'b0;
                    end else begin
                        state_d.st = CY_READ;
                        state_d.pins.ce_n = 1'b0;
                        state_d.pins.oe_n = 1'b0;
                    end
                end
            end
            CY_READ: begin
                // data counts once two synchronised samples agree
                if (state_q.cnt >= CNT_W'(ACCESS_CYC - 1) && state_q.s2 == state_q.s3) begin
                    state_d.rdata = state_q.s3;
                    state_d.pins.ce_n = 1'b1;
                    state_d.pins.oe_n = 1'b1;
                    state_d.st = CY_RECOVER;
                    state_d.cnt = '0;
                end
            end
            CY_STROBE: begin
                if (state_q.cnt == CNT_W'(STROBE_CYC - 1)) begin
                    if (ce_ctrl_i) begin
                        state_d.pins.ce_n = 1'b1;
                    end else begin
                        state_d.pins.we_n = 1'b1;
                    end
                    state_d.st = CY_HOLD;
                    state_d.cnt = '0;
                end
            end
            CY_HOLD: begin
                if (state_q.cnt == CNT_W'(ADDR_HOLD_CYC - 1)) begin
                    state_d.pins = PINS_IDLE;
                    state_d.pins.addr = state_q.pins.addr;
                    state_d.st = CY_RECOVER;
                    state_d.cnt = '0;
                end
            end
            CY_RECOVER: begin
                // covers strobe high time and output hold before next poll read
                if (state_q.cnt >= CNT_W'(WRITE_HIGH_CYC - 1) &&
                    state_q.cnt >= CNT_W'(POLL_OE_HOLD_CYC - 1)) begin
                    state_d.done = 1'b1;
                    state_d.st = CY_IDLE;
                end
            end
            default: begin
                state_d = CY_RESET;
            end
        endcase
    end

    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            state_q <= CY_RESET;
        end else begin
            state_q <= state_d;
        end
    end

    assign pins_o = state_q.pins;
    assign rdata_o = state_q.rdata;
    assign done_o = state_q.done;

endmodule : flash_bus_cycle
`default_nettype wire

/* File: hdl/flash_host.sv */
// host controller for a parallel nor flash: bus cycles, status polling, reset
`timescale 1ns/1ps
`default_nettype none
module flash_host #(
    parameter int unsigned PROGRAM_TIMEOUT = flash_host_pkg::PROGRAM_TIMEOUT_CYC,
    parameter int unsigned ERASE_TIMEOUT = flash_host_pkg::ERASE_TIMEOUT_CYC,
    parameter int unsigned RECOVERY_BUSY = flash_host_pkg::RECOVERY_BUSY_CYC
) (
    input wire logic core_clk_i,
    input wire logic rst_i,
    input wire logic cmd_valid_i,
    input wire flash_host_pkg::cmd_t cmd_i,
    input wire logic ce_ctrl_i,
    output logic cmd_ready_o,
    output logic rsp_valid_o,
    output flash_host_pkg::rsp_t rsp_o,
    output logic busy_o,
    output logic [flash_host_pkg::ADDR_W-1:0] flash_addr_o,
    output logic [flash_host_pkg::DATA_W-1:0] flash_dq_o,
    output logic flash_dq_oe_o,
    input wire logic [flash_host_pkg::DATA_W-1:0] flash_dq_i,
    output logic flash_ce_n_o,
    output logic flash_oe_n_o,
    output logic flash_we_n_o,
    output logic flash_reset_n_o
);
    import flash_host_pkg::*;

    typedef enum logic [2:0] {
        M_IDLE,
        M_CYCLE,
        M_POLL,
        M_RST_LOW,
        M_RST_WAIT
    } main_st_t;

    typedef struct packed {
        main_st_t st;
        cmd_t cmd;
        logic cyc_start;
        logic [DATA_W-1:0] prev;
        logic have_prev;
        logic [TMO_W-1:0] tmo;
        logic [TMO_W-1:0] cnt;
        logic algo_active;
        logic ready;
        logic rsp_valid;
        rsp_t rsp;
        logic rst_n;
    } main_state_t;

    // after our own reset the flash is reset too, assuming it may be busy
    localparam main_state_t MAIN_RESET = '{st: M_RST_LOW, cmd: '0, cyc_start: 1'b0,
        prev: '0, have_prev: 1'b0, tmo: '0, cnt: '0, algo_active: 1'b1, ready: 1'b0,
        rsp_valid: 1'b0, rsp: '0, rst_n: 1'b0};

    main_state_t state_q;
    main_state_t state_d;
    pins_t cyc_pins;
    logic [DATA_W-1:0] cyc_rdata;
    logic cyc_done;
    logic cyc_write;

    // ------------------------------------------------------------------
    // bus cycle engine
    // ------------------------------------------------------------------
    assign cyc_write = (state_q.cmd.op == OP_WRITE) || (state_q.cmd.op == OP_WRITE_START);

    flash_bus_cycle u_cycle (
        .core_clk_i(core_clk_i),
        .rst_i(rst_i),
        .start_i(state_q.cyc_start),
        .write_i(cyc_write),
        .ce_ctrl_i(ce_ctrl_i),
        .addr_i(state_q.cmd.addr),
        .data_i(state_q.cmd.data),
        .dq_i(flash_dq_i),
        .pins_o(cyc_pins),
        .rdata_o(cyc_rdata),
        .done_o(cyc_done)
    );

    // expected poll bit: erase ends at one, program at the written bit
    function automatic logic poll_expect(input cmd_t c);
        return c.erase ? 1'b1 : c.data[POLL_BIT];
    endfunction : poll_expect

    // ------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------
    always_comb begin
        state_d = state_q;
        state_d.cyc_start = 1'b0;
        state_d.rsp_valid = 1'b0;
        state_d.cnt = state_q.cnt + 1'b1;
        case (state_q.st)
            M_IDLE: begin
                state_d.cnt = '0;
                if (cmd_valid_i && state_q.ready) begin
                    state_d.cmd = cmd_i;
                    state_d.ready = 1'b0;
                    state_d.tmo = '0;
                    state_d.have_prev = 1'b0;
                    case (cmd_i.op)
                        OP_RESET: begin
                            state_d.rst_n = 1'b0;
                            state_d.st = M_RST_LOW;
                        end
                        OP_POLL_DATA, OP_POLL_TOGGLE: begin
                            // completion found by polling, not by waiting
                            state_d.cyc_start = 1'b1;
                            state_d.st = M_POLL;
                        end
                        default: begin
                            // sector select rides on the upper address bits
                            state_d.cyc_start = 1'b1;
                            state_d.st = M_CYCLE;
                        end
                    endcase
                end
            end
            M_CYCLE: begin
                if (cyc_done) begin
                    if (state_q.cmd.op == OP_WRITE_START) begin
                        state_d.algo_active = 1'b1;
                    end
                    state_d.rsp.data = cyc_rdata;
                    state_d.rsp.timeout = 1'b0;
                    state_d.rsp_valid = 1'b1;
                    state_d.ready = 1'b1;
                    state_d.st = M_IDLE;
                end
            end
            M_POLL: begin
                state_d.tmo = state_q.tmo + 1'b1;
                if (cyc_done) begin
                    state_d.prev = cyc_rdata;
                    state_d.have_prev = 1'b1;
                    state_d.rsp.data = cyc_rdata;
                    if (state_q.cmd.op == OP_POLL_DATA &&
                        cyc_rdata[POLL_BIT] == poll_expect(state_q.cmd)) begin
                        // device verified internally, no readback pass
                        state_d.rsp.timeout = 1'b0;
                        state_d.rsp_valid = 1'b1;
                        state_d.algo_active = 1'b0;
                        state_d.ready = 1'b1;
                        state_d.st = M_IDLE;
                    end else if (state_q.cmd.op == OP_POLL_TOGGLE && state_q.have_prev &&
                                 cyc_rdata[TOGGLE_BIT] == state_q.prev[TOGGLE_BIT]) begin
                        // toggle stopped: done, any address will do
                        state_d.rsp.timeout = 1'b0;
                        state_d.rsp_valid = 1'b1;
                        state_d.algo_active = 1'b0;
                        state_d.ready = 1'b1;
                        state_d.st = M_IDLE;
                    end else if (state_q.tmo >= (state_q.cmd.erase ? TMO_W'(ERASE_TIMEOUT) :
                                                 TMO_W'(PROGRAM_TIMEOUT))) begin
                        state_d.rsp.timeout = 1'b1;
                        state_d.rsp_valid = 1'b1;
                        state_d.ready = 1'b1;
                        state_d.st = M_IDLE;
                    end else begin
                        state_d.cyc_start = 1'b1;
                    end
                end
            end
            M_RST_LOW: begin
                if (state_q.cnt >= TMO_W'(RESET_LOW_CYC - 1)) begin
                    state_d.rst_n = 1'b1;
                    state_d.cnt = '0;
                    state_d.st = M_RST_WAIT;
                end
            end
            M_RST_WAIT: begin
                // idle recovery wait also covers the high time before a read; busy wait checks RECOVERY_BUSY alone
                if ((state_q.algo_active && state_q.cnt >= TMO_W'(RECOVERY_BUSY - 1)) ||
                    (!state_q.algo_active && state_q.cnt >= TMO_W'(RECOVERY_IDLE_CYC - 1) &&
                     state_q.cnt >= TMO_W'(RESET_HIGH_CYC - 1))) begin
                    state_d.algo_active = 1'b0;
                    state_d.ready = 1'b1;
                    state_d.rsp.timeout = 1'b0;
                    state_d.rsp.data = '0;
                    state_d.rsp_valid = (state_q.cmd.op == OP_RESET);
                    state_d.st = M_IDLE;
                end
            end
            default: begin
                state_d = MAIN_RESET;
            end
        endcase
    end

    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            state_q <= MAIN_RESET;
        end else begin
            state_q <= state_d;
        end
    end

    // ------------------------------------------------------------------
    // outputs, all from flip-flops
    // ------------------------------------------------------------------
    assign cmd_ready_o = state_q.ready;
    assign rsp_valid_o = state_q.rsp_valid;
    assign rsp_o = state_q.rsp;
    assign busy_o = state_q.algo_active;
    assign flash_reset_n_o = state_q.rst_n;
    assign flash_addr_o = cyc_pins.addr;
    assign flash_dq_o = cyc_pins.dq;
    assign flash_dq_oe_o = cyc_pins.dq_oe;
    assign flash_ce_n_o = cyc_pins.ce_n;
    assign flash_oe_n_o = cyc_pins.oe_n;
    assign flash_we_n_o = cyc_pins.we_n;

endmodule : flash_host
`default_nettype wire

/* File: include/flash_host_pkg.sv */
// types, pin layout and timing constants for the parallel nor flash host
package flash_host_pkg;

    // ------------------------------------------------------------------
    // geometry and status bit positions
    // ------------------------------------------------------------------
    localparam int ADDR_W = 19;
    localparam int DATA_W = 8;
    localparam int POLL_BIT = 7;
    localparam int TOGGLE_BIT = 6;
    localparam int SECTOR_LO = 13;
    localparam int SECTOR_HI = 18;
    localparam int CNT_W = 16;
    localparam int TMO_W = 32;

    // ------------------------------------------------------------------
    // timing, figures as printed
    // ------------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 10;
    localparam int WRITE_PULSE_NS = 35;
    localparam int WRITE_HIGH_NS = 30;
    localparam int ADDR_HOLD_NS = 45;
    localparam int DATA_SETUP_NS = 45;
    localparam int ACCESS_NS = 90;
    localparam int POLL_OE_HOLD_NS = 10;
    localparam int RESET_LOW_WIDTH_NS = 500;
    localparam int RESET_HIGH_BEFORE_READ_NS = 50;
    localparam int RESET_RECOVERY_BUSY_TIME_US = 20;
    localparam int RESET_RECOVERY_IDLE_TIME_NS = 500;
    localparam int BYTE_PROGRAM_MAX_US = 300;
    localparam int SECTOR_ERASE_MAX_S = 15;
    localparam int SYNC_LAT = 3;

    // least time to whole cycles, rounded up, never below one
    function automatic int ns_to_cyc(input longint t_ns);
        longint c;
        c = (t_ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
        return (c < 1) ? 1 : int'(c);
    endfunction : ns_to_cyc

    localparam int STROBE_CYC = (WRITE_PULSE_NS > DATA_SETUP_NS) ?
        ns_to_cyc(WRITE_PULSE_NS) : ns_to_cyc(DATA_SETUP_NS);
    localparam int WRITE_HIGH_CYC = ns_to_cyc(WRITE_HIGH_NS);
    localparam int ADDR_HOLD_CYC = ns_to_cyc(ADDR_HOLD_NS);
    localparam int ACCESS_CYC = ns_to_cyc(ACCESS_NS) + SYNC_LAT;
    localparam int POLL_OE_HOLD_CYC = ns_to_cyc(POLL_OE_HOLD_NS);
    localparam int RESET_LOW_CYC = ns_to_cyc(RESET_LOW_WIDTH_NS);
    localparam int RESET_HIGH_CYC = ns_to_cyc(RESET_HIGH_BEFORE_READ_NS);
    localparam int RECOVERY_BUSY_CYC = ns_to_cyc(longint'(RESET_RECOVERY_BUSY_TIME_US) * 1000);
    localparam int RECOVERY_IDLE_CYC = ns_to_cyc(RESET_RECOVERY_IDLE_TIME_NS);
    localparam int PROGRAM_TIMEOUT_CYC = ns_to_cyc(longint'(BYTE_PROGRAM_MAX_US) * 1000);
    localparam int ERASE_TIMEOUT_CYC =
        ns_to_cyc(longint'(SECTOR_ERASE_MAX_S) * 64'd1000000000);

    // ------------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        OP_READ,
        OP_WRITE,
        OP_WRITE_START,
        OP_POLL_DATA,
        OP_POLL_TOGGLE,
        OP_RESET
    } op_t;

    typedef struct packed {
        op_t op;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
        logic erase;
    } cmd_t;

    typedef struct packed {
        logic [DATA_W-1:0] data;
        logic timeout;
    } rsp_t;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] dq;
        logic dq_oe;
        logic ce_n;
        logic oe_n;
        logic we_n;
    } pins_t;

    localparam pins_t PINS_IDLE = '{addr: '0, dq: '0, dq_oe: 1'b0,
                                   ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1};

endpackage : flash_host_pkg

/* File: testbench/flash_host_monitor.sv */
// assertion checker for the flash host command port and flash pins
`timescale 1ns/1ps
`default_nettype none
module flash_host_monitor
    import flash_host_pkg::*;
(
    input wire logic core_clk_i,
    input wire logic rst_i,
    input wire logic cmd_valid_i,
    input wire cmd_t cmd_i,
    input wire logic ce_ctrl_i,
    input wire logic cmd_ready_o,
    input wire logic rsp_valid_o,
    input wire logic busy_o,
    input wire logic [ADDR_W-1:0] flash_addr_o,
    input wire logic [DATA_W-1:0] flash_dq_o,
    input wire logic flash_dq_oe_o,
    input wire logic flash_ce_n_o,
    input wire logic flash_oe_n_o,
    input wire logic flash_we_n_o,
    input wire logic flash_reset_n_o
);
    // ------------------------------------------------------------------
    // flash reset low time counter
    // ------------------------------------------------------------------
    logic [7:0] low_cnt_q;
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) low_cnt_q <= 8'h00;
        else if (flash_reset_n_o) low_cnt_q <= 8'h00;
        else if (low_cnt_q != 8'hFF) low_cnt_q <= low_cnt_q + 8'h01;
    end

    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (rst_i);

    sequence s_start_take;
        cmd_valid_i && cmd_ready_o && cmd_i.op == OP_WRITE_START;
    endsequence
    sequence s_answer_busy;
        rsp_valid_o && busy_o;
    endsequence

    reset_width_a: assert property ($rose(flash_reset_n_o) |-> low_cnt_q >= 8'h32)
        else $error("flash reset released too early");
    reset_settle_a: assert property ($rose(flash_reset_n_o) |-> flash_oe_n_o [*5])
        else $error("read started too soon after flash reset");
    take_drop_a: assert property (cmd_valid_i && cmd_ready_o |=> !cmd_ready_o)
        else $error("ready stayed high after a take");
    rsp_pulse_a: assert property (rsp_valid_o |=> !rsp_valid_o)
        else $error("response valid longer than one cycle");
    ready_rsp_a: assert property (rsp_valid_o |-> cmd_ready_o)
        else $error("ready not high with the response");
    idle_rsp_a: assert property (rsp_valid_o |-> flash_ce_n_o && flash_oe_n_o && flash_we_n_o)
        else $error("flash strobes active at response");
    strobe_drive_a: assert property (!flash_we_n_o |-> flash_oe_n_o && flash_dq_oe_o)
        else $error("write strobe without driven data");
    we_pulse_a: assert property ($fell(flash_we_n_o) && !ce_ctrl_i |->
        (!flash_we_n_o && !flash_ce_n_o) [*4])
        else $error("write strobe pulse too short");
    ce_pulse_a: assert property ($fell(flash_ce_n_o) && !flash_we_n_o |->
        (!flash_ce_n_o && !flash_we_n_o) [*4])
        else $error("chip select write pulse too short");
    strobe_gap_a: assert property ($rose(flash_we_n_o) |-> flash_we_n_o [*3])
        else $error("write strobe high time too short");
    strobe_hold_a: assert property (!flash_we_n_o && $past(!flash_we_n_o) |->
        $stable(flash_addr_o) && $stable(flash_dq_o))
        else $error("address or data moved during a write");
    start_busy_a: assert property (s_start_take |-> ##[1:30] s_answer_busy)
        else $error("busy not reported after algorithm start");
endmodule : flash_host_monitor

bind flash_host flash_host_monitor u_flash_host_monitor (.*);
`default_nettype wire

/* File: testbench/flash_model.sv */
// behavioural parallel nor flash device for the host bench
`timescale 1ns/1ps
`default_nettype none
module flash_model #(
    parameter logic [7:0] PROG_CODE = 8'h5A, // command codes arbitrary
    parameter logic [7:0] ERASE_CODE = 8'h6B,
    parameter logic [7:0] CHIP_CODE = 8'h3D,
    parameter int PROG_NS = 900,
    parameter int ERASE_NS = 3000,
    parameter int READY_BUSY_NS = 600,
    parameter int READY_IDLE_NS = 500
) (
    input wire logic [18:0] addr_i,
    input wire logic [7:0] dq_i,
    input wire logic ce_n_i,
    input wire logic oe_n_i,
    input wire logic we_n_i,
    input wire logic reset_n_i,
    output logic [7:0] dq_o,
    output int n_err_o
);
    logic [7:0] mem [int];
    logic busy = 1'b0;
    logic is_erase = 1'b0;
    logic tog = 1'b0;
    logic [1:0] armed = 2'h0;
    logic [7:0] wr_byte = 8'h00;
    logic [7:0] last = 8'h00;
    int gen = 0;
    realtime ready_at = 0;
    initial n_err_o = 0;
    initial dq_o = 8'h00;

    function automatic logic [7:0] rd(input int a);
        return mem.exists(a) ? mem[a] : 8'hFF;
    endfunction : rd

    task automatic run(input int t_ns, input logic er);
        int g;
        gen++;
        g = gen;
        busy = 1'b1;
        is_erase = er;
        fork
            begin
                #(t_ns); // scaled typical durations
                if (g == gen) busy = 1'b0;
            end
        join_none
    endtask : run

    always @(posedge we_n_i or posedge ce_n_i) begin
        if (we_n_i != ce_n_i) begin // either strobe latches
            if (!reset_n_i || $realtime < ready_at) n_err_o++;
            if (!busy && armed == 2'h1) begin
                mem[int'(addr_i)] = rd(int'(addr_i)) & dq_i; // self-verified byte
                wr_byte = dq_i;
                run(PROG_NS, 1'b0);
            end else if (!busy && armed == 2'h2) begin
                foreach (mem[k])
                    if (dq_i == CHIP_CODE || k[18:13] == addr_i[18:13]) mem[k] = 8'hFF;
                run(ERASE_NS, 1'b1);
            end
            armed = (armed != 2'h0) ? 2'h0 : (dq_i == PROG_CODE) ? 2'h1 :
                    (dq_i == ERASE_CODE) ? 2'h2 : 2'h0;
        end
    end

    always @(negedge oe_n_i or negedge ce_n_i) begin
        if (!oe_n_i && !ce_n_i) begin
            if (!reset_n_i || $realtime < ready_at) n_err_o++;
            #20;
            if (busy) begin
                last = {is_erase ? 1'b0 : ~wr_byte[7], tog, 6'h00}; // any address
                tog = ~tog;
            end else last = rd(int'(addr_i)); // true value when done
            dq_o = last;
        end
    end

    // released bus shows the inverse of the last byte
    always @(posedge oe_n_i or posedge ce_n_i) dq_o <= #10 ~last;

    always @(negedge reset_n_i) begin
        ready_at = $realtime + (busy ? READY_BUSY_NS : READY_IDLE_NS);
        gen++;
        busy = 1'b0;
        armed = 2'h0;
    end
endmodule : flash_model
`default_nettype wire

/* File: testbench/test_flash_host.sv */
// self-checking bench for the flash host against a behavioural flash
`timescale 1ns/1ps
`default_nettype none
module test_flash_host;
    import flash_host_pkg::*;
    localparam logic [7:0] PROG = 8'h5A, ERASE = 8'h6B, SECTOR = 8'h7C, CHIP = 8'h3D;
    localparam int LIMIT = 20000;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic cmd_valid = 1'b0;
    cmd_t cmd = '0;
    logic ce_ctrl = 1'b0;
    logic cmd_ready, rsp_valid, busy, dq_oe, ce_n, oe_n, we_n, reset_n;
    rsp_t rsp;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] dq_host, dq_dev, dq_bus;
    int model_err;
    int n_mismatch = 0;
    int tests_run = 0;

    assign dq_bus = dq_oe ? dq_host : dq_dev;
    always #5 core_clk = ~core_clk;

    flash_host #(.PROGRAM_TIMEOUT(200), .ERASE_TIMEOUT(500), .RECOVERY_BUSY(20)) u_flash_host (
        .core_clk_i(core_clk), .rst_i(rst), .cmd_valid_i(cmd_valid), .cmd_i(cmd),
        .ce_ctrl_i(ce_ctrl), .cmd_ready_o(cmd_ready), .rsp_valid_o(rsp_valid), .rsp_o(rsp),
        .busy_o(busy), .flash_addr_o(addr), .flash_dq_o(dq_host), .flash_dq_oe_o(dq_oe),
        .flash_dq_i(dq_bus), .flash_ce_n_o(ce_n), .flash_oe_n_o(oe_n), .flash_we_n_o(we_n),
        .flash_reset_n_o(reset_n));
    flash_model #(.PROG_CODE(PROG), .ERASE_CODE(ERASE),
        .CHIP_CODE(CHIP)) u_flash_model (.addr_i(addr), .dq_i(dq_bus), .ce_n_i(ce_n),
        .oe_n_i(oe_n), .we_n_i(we_n), .reset_n_i(reset_n), .dq_o(dq_dev), .n_err_o(model_err));

    // ------------------------------------------------------------------
    // report and compare
    // ------------------------------------------------------------------
    task automatic print_verdict;
        if (n_mismatch == 0 && tests_run > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : print_verdict

    task automatic chk_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
        tests_run++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask : chk_byte

    task automatic chk_bit(input string what, input logic exp, input logic got);
        tests_run++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH %s expected %b seen %b", what, exp, got);
        end
    endtask : chk_bit

    // ------------------------------------------------------------------
    // command helpers
    // ------------------------------------------------------------------
    task automatic issue(input op_t op, input logic [18:0] a, input logic [7:0] d, input logic e);
        int i;
        for (i = 0; i < LIMIT && cmd_ready !== 1'b1; i++) @(negedge core_clk);
        cmd = '{op: op, addr: a, data: d, erase: e};
        cmd_valid = 1'b1;
        @(negedge core_clk);
        cmd_valid = 1'b0;
        for (; i < LIMIT && rsp_valid !== 1'b1; i++) @(negedge core_clk);
        if (i == LIMIT) begin
            n_mismatch++;
            print_verdict();
        end
    endtask : issue

    task automatic prog(input logic [18:0] a, input logic [7:0] d);
        issue(OP_WRITE, a, PROG, 1'b0);
        issue(OP_WRITE_START, a, d, 1'b0);
    endtask : prog

    task automatic erase_cmd(input logic [18:0] a, input logic [7:0] code);
        issue(OP_WRITE, a, ERASE, 1'b0);
        issue(OP_WRITE_START, a, code, 1'b1);
    endtask : erase_cmd

    task automatic poll(input op_t op, input logic [18:0] a, input logic e,
                        input logic [7:0] exp, input logic tmo);
        issue(op, a, exp, e);
        chk_bit("timeout", tmo, rsp.timeout);
        if (!tmo) chk_byte("poll data", exp, rsp.data);
        @(negedge core_clk);
        chk_bit("busy", tmo, busy);
    endtask : poll

    task automatic rd_chk(input logic [18:0] a, input logic [7:0] exp);
        issue(OP_READ, a, 8'h00, 1'b0);
        chk_byte("read data", exp, rsp.data);
    endtask : rd_chk

    // ------------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------------
    task automatic t_program;
        ce_ctrl = 1'b0;
        prog(19'h0_1234, 8'hC3);
        poll(OP_POLL_DATA, 19'h0_1234, 1'b0, 8'hC3, 1'b0);
        rd_chk(19'h0_1234, 8'hC3);
        ce_ctrl = 1'b1;
        prog(19'h4_1FFF, 8'h3C);
        poll(OP_POLL_TOGGLE, 19'h0_0000, 1'b0, 8'hFF, 1'b0);
        rd_chk(19'h4_1FFF, 8'h3C);
        ce_ctrl = 1'b0;
    endtask : t_program

    task automatic t_erase;
        prog(19'h4_2000, 8'h5F);
        poll(OP_POLL_DATA, 19'h4_2000, 1'b0, 8'h5F, 1'b0);
        erase_cmd(19'h4_0000, SECTOR);
        poll(OP_POLL_DATA, 19'h4_1FFF, 1'b1, 8'hFF, 1'b0);
        rd_chk(19'h4_1FFF, 8'hFF);
        rd_chk(19'h4_2000, 8'h5F);
        rd_chk(19'h0_1234, 8'hC3);
        erase_cmd(19'h0_0000, CHIP);
        poll(OP_POLL_TOGGLE, 19'h7_FFFF, 1'b1, 8'hFF, 1'b0);
        rd_chk(19'h4_2000, 8'hFF);
        rd_chk(19'h0_1234, 8'hFF);
    endtask : t_erase

    task automatic t_timeout;
        prog(19'h0_0100, 8'h00);
        poll(OP_POLL_DATA, 19'h0_0100, 1'b0, 8'h00, 1'b0);
        prog(19'h0_0100, 8'h80);
        poll(OP_POLL_DATA, 19'h0_0100, 1'b0, 8'h80, 1'b1);
        issue(OP_RESET, 19'h0_0000, 8'h00, 1'b0);
        @(negedge core_clk);
        chk_bit("busy", 1'b0, busy);
        rd_chk(19'h0_0100, 8'h00);
    endtask : t_timeout

    task automatic t_reset;
        issue(OP_RESET, 19'h0_0000, 8'h00, 1'b0);
        @(negedge core_clk);
        chk_bit("busy", 1'b0, busy);
        prog(19'h0_0200, 8'h11);
        issue(OP_RESET, 19'h0_0000, 8'h00, 1'b0);
        @(negedge core_clk);
        chk_bit("busy", 1'b0, busy);
        rd_chk(19'h0_0100, 8'h00);
        chk_byte("early access count", 8'h00, 8'(model_err));
    endtask : t_reset

    initial begin
        repeat (6) @(negedge core_clk);
        rst = 1'b0;
        t_program();
        t_erase();
        t_timeout();
        t_reset();
        print_verdict();
    end
endmodule : test_flash_host
`default_nettype wire
